/* File: crst_pkg.sv */
// Purpose: Shared constants and types for the rotate, subtract and table-read execution unit.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Opcode prefixes sit in bits 15:8 of the 16-bit instruction word.
package crst_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_TPB = 8'h00;
  localparam logic [7:0] OFS_INSTR = 8'h04;
  localparam logic [7:0] OFS_ACC = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_DPTR = 8'h10;
  localparam logic [7:0] OFS_DDATA = 8'h14;

  // ----------------------------------------------------------------
  // Status bit positions and reset values
  // ----------------------------------------------------------------
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_ILLEGAL = 4;
  localparam int ST_SLEEP = 5;
  localparam int ST_BUSY = 6;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // ----------------------------------------------------------------
  // Instruction encodings
  // ----------------------------------------------------------------
  localparam int BIT_IND = 7;
  localparam int BIT_DEST = 6;
  localparam logic [7:0] OPC_ROTL = 8'h1C;
  localparam logic [7:0] OPC_ROTR = 8'h1D;
  localparam logic [7:0] OPC_SUBF = 8'h1F;
  localparam logic [7:0] OPC_SWAP = 8'h1A;
  localparam logic [7:0] OPC_SKIP_ON_ZERO_OP = 8'h20;
  localparam logic [7:0] OPC_SUBL = 8'h0D;
  localparam logic [7:0] OPC_XORL = 8'h0B;
  localparam logic [7:0] OPC_TBL = 8'h2F;
  localparam logic [15:0] OPC_SLEEP = 16'h0202;

  // ----------------------------------------------------------------
  // Execution states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CRST_IDLE = 3'b000,
    CRST_INDIR = 3'b001,
    CRST_EXEC = 3'b010,
    CRST_TBL = 3'b011,
    CRST_SKIP = 3'b100,
    CRST_SLEEP = 3'b101
  } crst_state_t;

endpackage

/* File: crst_core.sv */
// Purpose: Executes rotate, skip, sleep, subtract, swap, xor and table-read instructions.
// Assumes: Instructions are issued by an APB write to the instruction register.
// Notes: Program memory read port is combinational, sampled one cycle after the address.
//
// How it works
// RQ1: Rotate-left prefix 1C decoded; bit 7 indirect; one cycle direct, two indirect.
// RQ2: Rotate-left shifts up, carry into bit 0, old bit 7 to carry only.
// RQ3: Rotate-right prefix 1D decoded; bit 7 indirect; one cycle direct, two indirect.
// RQ4: Rotate-right shifts down, carry into bit 7, old bit 0 to carry only.
// RQ5: Skip-on-zero tests operand, skips next when zero, extra cycle, flags untouched.
// RQ6: Sleep takes one cycle and halts until any enabled interrupt, ignoring global enable.
// RQ7: While asleep the instruction oscillator stops and analog power stays on.
// RQ8: Subtract-W-from-register writes register minus W to W or register.
// RQ9: Both subtracts set carry, half carry and zero from the result.
// RQ10: Subtract-immediate takes the literal from W into W in one cycle.
// RQ11: Nibble exchange swaps halves of operand into W or register, no flags.
// RQ12: Xor-immediate into W in one cycle, zero flag follows the result.
// RQ13: Table read takes two cycles, loads a program byte into W, no flags.
// RQ14: Table address is page base bits 5:0 above operand bits 7:1.
// RQ15: Odd operand returns upper program byte, even operand the lower byte.
// RQ16: Bit 6 set writes the register, clear writes W.
// RQ17: Indirect bit uses register contents as data address, costing one cycle.
`timescale 1ns/100ps
module crst_core
  import crst_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int PM_AW = 13,
  parameter int DM_DEPTH = 256
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [PM_AW-1:0] pm_addr,
  output logic pm_rd,
  input wire logic [15:0] pm_rdata,
  input wire logic irq_wake,
  output logic osc_run,
  output logic analog_pwr_en,
  output logic skip_next
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Subtract b from a; returns {carry, half carry, result}, carry meaning no borrow.
  function automatic logic [9:0] sub8(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, a} + {1'b0, ~b} + 9'h001;
    low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
    return {full[8], low[4], full[7:0]};
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  crst_state_t state_reg, state_next;
  logic [15:0] op_reg, op_next;
  logic [7:0] ea_reg, ea_next;
  logic [7:0] acc_reg, acc_next;
  logic c_reg, c_next, dc_reg, dc_next, z_reg, z_next;
  logic illegal_reg, illegal_next;
  logic [7:0] tpb_reg, tpb_next;
  logic [7:0] dptr_reg, dptr_next;
  logic bsel_reg, bsel_next;
  logic [PM_AW-1:0] pm_addr_reg, pm_addr_next;
  logic pm_rd_reg, pm_rd_next;
  logic osc_run_reg, osc_run_next;
  logic analog_reg;
  logic skip_reg, skip_next_v;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [7:0] dmem [DM_DEPTH];
  logic dm_we;
  logic [7:0] dm_waddr, dm_wdata;

  // Decoded fields of the held instruction.
  logic [7:0] opnd, res;
  logic [9:0] subr;
  logic is_rotl, is_rotr, is_subf, is_swap, is_skip_on_zero_op, is_subl, is_xorl, is_tbl, is_sleep, reg_fmt;
  logic xfer_done, wr_ok, addr_hit;
  logic [7:0] status_byte;

  assign opnd = dmem[ea_reg];
  assign is_rotl = op_reg[15:8] == OPC_ROTL; // [RQ1]
  assign is_rotr = op_reg[15:8] == OPC_ROTR; // [RQ3]
  assign is_subf = op_reg[15:8] == OPC_SUBF; // [RQ8]
  assign is_swap = op_reg[15:8] == OPC_SWAP; // [RQ11]
  assign is_skip_on_zero_op = op_reg[15:8] == OPC_SKIP_ON_ZERO_OP && !op_reg[BIT_DEST]; // [RQ5]
  assign is_subl = op_reg[15:8] == OPC_SUBL; // [RQ10]
  assign is_xorl = op_reg[15:8] == OPC_XORL; // [RQ12]
  assign is_tbl = op_reg[15:6] == {OPC_TBL, 2'b01}; // [RQ13]
  assign is_sleep = op_reg == OPC_SLEEP; // [RQ6]
  assign reg_fmt = is_rotl || is_rotr || is_subf || is_swap || is_skip_on_zero_op;
  assign subr = is_subl ? sub8(acc_reg, op_reg[7:0]) : sub8(opnd, acc_reg); // [RQ9]
  assign status_byte = {1'b0, state_reg != CRST_IDLE, state_reg == CRST_SLEEP, illegal_reg,
                        1'b0, z_reg, dc_reg, c_reg};

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign xfer_done = psel && penable && pready_reg;
  assign wr_ok = xfer_done && pwrite && !pslverr_reg;
  assign addr_hit = paddr == OFS_TPB || paddr == OFS_INSTR || paddr == OFS_ACC ||
                    paddr == OFS_STATUS || paddr == OFS_DPTR || paddr == OFS_DDATA;

  // Inserts one wait cycle so that read data and error come from flip-flops.
  always_comb begin
    pready_next = psel && penable && !pready_reg;
    pslverr_next = pready_next && !addr_hit;
    prdata_next = 32'h0000_0000;
    if (pready_next && !pwrite) begin
      case (paddr)
        OFS_TPB: prdata_next = {24'h000000, tpb_reg};
        OFS_INSTR: prdata_next = {16'h0000, op_reg};
        OFS_ACC: prdata_next = {24'h000000, acc_reg};
        OFS_STATUS: prdata_next = {24'h000000, status_byte};
        OFS_DPTR: prdata_next = {24'h000000, dptr_reg};
        OFS_DDATA: prdata_next = {24'h000000, dmem[dptr_reg]};
        default: prdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Registers the bus answer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Execution
  // ----------------------------------------------------------------
  // Computes the next core state, flags and memory write for each instruction.
  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    ea_next = ea_reg;
    acc_next = acc_reg;
    c_next = c_reg;
    dc_next = dc_reg;
    z_next = z_reg;
    illegal_next = illegal_reg;
    tpb_next = tpb_reg;
    dptr_next = dptr_reg;
    bsel_next = bsel_reg;
    pm_addr_next = pm_addr_reg;
    pm_rd_next = 1'b0;
    osc_run_next = osc_run_reg;
    skip_next_v = 1'b0;
    dm_we = 1'b0;
    dm_waddr = ea_reg;
    dm_wdata = 8'h00;
    res = 8'h00;
    // Software writes; page base and pointer at any time, the rest only while idle.
    if (wr_ok && paddr == OFS_TPB) begin
      tpb_next = pwdata[7:0];
    end
    if (wr_ok && paddr == OFS_DPTR) begin
      dptr_next = pwdata[7:0];
    end
    if (wr_ok && state_reg == CRST_IDLE) begin
      case (paddr)
        OFS_ACC: acc_next = pwdata[7:0];
        OFS_STATUS: begin
          c_next = pwdata[ST_C];
          dc_next = pwdata[ST_DC];
          z_next = pwdata[ST_Z];
          if (pwdata[ST_ILLEGAL]) begin
            illegal_next = 1'b0;
          end
        end
        OFS_DDATA: begin
          dm_we = 1'b1;
          dm_waddr = dptr_reg;
          dm_wdata = pwdata[7:0];
        end
        OFS_INSTR: begin
          op_next = pwdata[15:0];
          ea_next = {2'b00, pwdata[5:0]};
          // Only register formats go indirect; in literal formats bit 7 is part of the data.
          state_next = pwdata[BIT_IND] && pwdata[15:8] inside {OPC_ROTL, OPC_ROTR, OPC_SUBF, OPC_SWAP, OPC_SKIP_ON_ZERO_OP} ?
                       CRST_INDIR : CRST_EXEC; // [RQ17]
        end
        default: state_next = state_reg;
      endcase
    end
    case (state_reg)
      CRST_IDLE: state_next = state_next;
      CRST_INDIR: begin
        ea_next = opnd; // [RQ17]
        state_next = CRST_EXEC;
      end
      CRST_EXEC: begin
        state_next = CRST_IDLE;
        if (is_rotl) begin
          res = {opnd[6:0], c_reg}; // [RQ2]
          c_next = opnd[7];
        end else if (is_rotr) begin
          res = {c_reg, opnd[7:1]}; // [RQ4]
          c_next = opnd[0];
        end else if (is_subf || is_subl) begin
          res = subr[7:0]; // [RQ9]
          c_next = subr[9];
          dc_next = subr[8];
          z_next = subr[7:0] == 8'h00;
        end else if (is_swap) begin
          res = {opnd[3:0], opnd[7:4]}; // [RQ11]
        end else if (is_xorl) begin
          res = acc_reg ^ op_reg[7:0]; // [RQ12]
          z_next = res == 8'h00;
        end
        if (is_rotl || is_rotr || is_subf || is_swap) begin
          if (op_reg[BIT_DEST]) begin
            dm_we = 1'b1; // [RQ16]
            dm_wdata = res;
          end else begin
            acc_next = res;
          end
        end else if (is_subl || is_xorl) begin
          acc_next = res; // [RQ10]
        end else if (is_skip_on_zero_op) begin
          if (opnd == 8'h00) begin
            state_next = CRST_SKIP; // [RQ5]
            skip_next_v = 1'b1;
          end
        end else if (is_tbl) begin
          pm_addr_next = {tpb_reg[5:0], opnd[7:1]}; // [RQ14]
          bsel_next = opnd[0];
          pm_rd_next = 1'b1;
          state_next = CRST_TBL;
        end else if (is_sleep) begin
          osc_run_next = 1'b0; // [RQ7]
          state_next = CRST_SLEEP;
        end else if (!reg_fmt) begin
          illegal_next = 1'b1;
        end
      end
      CRST_TBL: begin
        acc_next = bsel_reg ? pm_rdata[15:8] : pm_rdata[7:0]; // [RQ15]
        state_next = CRST_IDLE;
      end
      CRST_SKIP: state_next = CRST_IDLE;
      CRST_SLEEP: begin
        if (irq_wake) begin
          osc_run_next = 1'b1; // [RQ6]
          state_next = CRST_IDLE;
        end
      end
      default: state_next = CRST_IDLE;
    endcase
  end

  // Registers the core state; the data file is written by its own block below.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= CRST_IDLE;
      op_reg <= RST_WORD;
      ea_reg <= RST_BYTE;
      acc_reg <= RST_BYTE;
      c_reg <= 1'b0;
      dc_reg <= 1'b0;
      z_reg <= 1'b0;
      illegal_reg <= 1'b0;
      tpb_reg <= RST_BYTE;
      dptr_reg <= RST_BYTE;
      bsel_reg <= 1'b0;
      pm_addr_reg <= '0;
      pm_rd_reg <= 1'b0;
      osc_run_reg <= 1'b1;
      analog_reg <= 1'b1;
      skip_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      ea_reg <= ea_next;
      acc_reg <= acc_next;
      c_reg <= c_next;
      dc_reg <= dc_next;
      z_reg <= z_next;
      illegal_reg <= illegal_next;
      tpb_reg <= tpb_next;
      dptr_reg <= dptr_next;
      bsel_reg <= bsel_next;
      pm_addr_reg <= pm_addr_next;
      pm_rd_reg <= pm_rd_next;
      osc_run_reg <= osc_run_next;
      analog_reg <= 1'b1; // [RQ7]
      skip_reg <= skip_next_v;
    end
  end

  // Data file write port; contents are not reset.
  always_ff @(posedge pclk) begin
    if (dm_we) begin
      dmem[dm_waddr] <= dm_wdata;
    end
  end

  // Outputs straight from flip-flops.
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign pm_addr = pm_addr_reg;
  assign pm_rd = pm_rd_reg;
  assign osc_run = osc_run_reg;
  assign analog_pwr_en = analog_reg;
  assign skip_next = skip_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_rotl_carry: assert property (state_reg == CRST_EXEC && is_rotl |=> c_reg == $past(opnd[7]) && // [RQ2]
    $stable(z_reg) && $stable(dc_reg)) else $error("rotate left carry wrong");
  a_rotr_carry: assert property (state_reg == CRST_EXEC && is_rotr && !op_reg[BIT_DEST] |=> // [RQ4]
    acc_reg == {$past(c_reg), $past(opnd[7:1])} && c_reg == $past(opnd[0])) else $error("rotate right wrong");
  a_ind_extra: assert property (state_reg == CRST_IDLE && wr_ok && paddr == OFS_INSTR && pwdata[BIT_IND] && // [RQ17]
    pwdata[15:8] == OPC_ROTL |=> state_reg == CRST_INDIR ##1 state_reg == CRST_EXEC ##1 state_reg == CRST_IDLE)
    else $error("indirect operand timing wrong");
  a_skip_cycle: assert property (state_reg == CRST_EXEC && is_skip_on_zero_op && opnd == 8'h00 |=> // [RQ5]
    skip_next && state_reg == CRST_SKIP ##1 !skip_next && state_reg == CRST_IDLE) else $error("skip timing wrong");
  a_sleep_osc: assert property (state_reg == CRST_EXEC && is_sleep |=> state_reg == CRST_SLEEP && !osc_run && // [RQ7]
    analog_pwr_en) else $error("oscillator not stopped in sleep");
  a_sleep_hold: assert property (state_reg == CRST_SLEEP && !irq_wake |=> state_reg == CRST_SLEEP && !osc_run && // [RQ6]
    analog_pwr_en) else $error("sleep left without wake");
  a_sleep_wake: assert property (state_reg == CRST_SLEEP && irq_wake |=> osc_run && // [RQ6]
    state_reg == CRST_IDLE) else $error("sleep wake wrong");
  a_sub_flags: assert property (state_reg == CRST_EXEC && is_subf |=> // [RQ9]
    c_reg == ($past(opnd) >= $past(acc_reg)) && dc_reg == ($past(opnd[3:0]) >= $past(acc_reg[3:0])) &&
    z_reg == ($past(opnd) == $past(acc_reg))) else $error("subtract flags wrong");
  a_subl_flags: assert property (state_reg == CRST_EXEC && is_subl |=> // [RQ9]
    c_reg == ($past(acc_reg) >= $past(op_reg[7:0])) && dc_reg == ($past(acc_reg[3:0]) >= $past(op_reg[3:0])) &&
    z_reg == ($past(acc_reg) == $past(op_reg[7:0]))) else $error("subtract literal flags wrong");
  a_subl_cycle: assert property (state_reg == CRST_IDLE && wr_ok && paddr == OFS_INSTR && pwdata[BIT_IND] && // [RQ10]
    pwdata[15:8] == OPC_SUBL |=> state_reg == CRST_EXEC ##1 state_reg == CRST_IDLE) else $error("literal timing wrong");
  a_subl_acc: assert property (state_reg == CRST_EXEC && is_subl |=> // [RQ10]
    acc_reg == $past(acc_reg) - $past(op_reg[7:0])) else $error("subtract literal wrong");
  a_xor_zero: assert property (state_reg == CRST_EXEC && is_xorl |=> // [RQ12]
    z_reg == (acc_reg == 8'h00) && acc_reg == ($past(acc_reg) ^ $past(op_reg[7:0]))) else $error("xor wrong");
  a_tbl_addr: assert property (state_reg == CRST_EXEC && is_tbl |=> // [RQ14]
    pm_rd && pm_addr == {$past(tpb_reg[5:0]), $past(opnd[7:1])} ##1 state_reg == CRST_IDLE)
    else $error("table address wrong");
  a_tbl_byte: assert property (state_reg == CRST_TBL |=> acc_reg == ($past(bsel_reg) ? // [RQ15]
    $past(pm_rdata[15:8]) : $past(pm_rdata[7:0])) && $stable(c_reg)) else $error("table byte wrong");

endmodule

/* File: tb_top.sv */
// Purpose: Self-checking bench for the rotate, subtract, swap, skip, sleep and table-read unit.
// Assumes: APB slave answers after one wait state; program memory is modelled combinationally.
// Notes: Cycle timing is guarded by assertions inside the design; this bench checks results.
`timescale 1ns/100ps
module tb_top;
  import crst_pkg::*;

  // ----------------------------------------------------------------
  // Signals and clock
  // ----------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [12:0] pm_addr;
  logic pm_rd;
  logic [15:0] pm_rdata;
  logic irq_wake = 1'b0;
  logic osc_run;
  logic analog_pwr_en;
  logic skip_next;
  int num_errors = 0;
  int comparisons = 0;
  int skip_cnt = 0;
  int pmrd_cnt = 0;
  int snap = 0;
  logic [31:0] rv;
  logic ev;

  // Clock of 125 MHz.
  always #4 pclk = ~pclk;

  // Program word is a known pattern of its own address.
  assign pm_rdata = {3'b101, pm_addr};

  crst_core u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_rdata(pm_rdata), .irq_wake(irq_wake),
    .osc_run(osc_run), .analog_pwr_en(analog_pwr_en), .skip_next(skip_next)
  );

  // Counts single-cycle pulses of skip and program-read strobes.
  always @(posedge pclk) begin
    if (skip_next === 1'b1) skip_cnt++;
    if (pm_rd === 1'b1) pmrd_cnt++;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Prints the verdict and ends the run.
  task automatic close_out();
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Compares a seen value with the expected one.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      close_out();
    end
  endtask

  // Register write and read shorthands.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    xfer(1'b0, a, 32'h00000000, q, e);
  endtask

  // Data file access through the pointer and data window.
  task automatic fset(input logic [7:0] idx, input logic [7:0] v);
    wr(OFS_DPTR, {24'h000000, idx});
    wr(OFS_DDATA, {24'h000000, v});
  endtask

  task automatic fget(input logic [7:0] idx, output logic [31:0] q);
    wr(OFS_DPTR, {24'h000000, idx});
    rd(OFS_DDATA, q);
  endtask

  // Issues an instruction and polls until the unit is idle.
  task automatic run(input logic [15:0] op);
    logic [31:0] s;
    int n;
    wr(OFS_INSTR, {16'h0000, op});
    n = 0;
    do begin
      rd(OFS_STATUS, s);
      n++;
    end while (s[ST_BUSY] !== 1'b0 && n < 20);
    if (n >= 20) begin
      num_errors++;
      close_out();
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and an unmapped access.
    rd(OFS_TPB, rv); check("tpb_reset", rv, 32'h00000000);
    rd(OFS_ACC, rv); check("acc_reset", rv, 32'h00000000);
    rd(OFS_STATUS, rv); check("status_reset", rv, 32'h00000000);
    xfer(1'b0, 8'h18, 32'h00000000, rv, ev); check("unmapped_err", {31'h0, ev}, 32'h00000001);
    check("unmapped_data", rv, 32'h00000000);
    // Rotate left through carry, carry in 1, old top bit 0.
    fset(8'h03, 8'h01); wr(OFS_STATUS, 32'h00000007);
    run(16'h1C43);
    fget(8'h03, rv); check("rotl_val", rv, 32'h00000003);
    rd(OFS_STATUS, rv); check("rotl_flags", rv, 32'h00000006);
    // Rotate right into W, old bit 0 into carry.
    fset(8'h04, 8'h03); wr(OFS_STATUS, 32'h00000006);
    run(16'h1D04);
    rd(OFS_ACC, rv); check("rotr_w", rv, 32'h00000001);
    rd(OFS_STATUS, rv); check("rotr_flags", rv, 32'h00000007);
    fget(8'h04, rv); check("rotr_src", rv, 32'h00000003);
    // Indirect rotate right, carry in 1, writes file byte 4 through pointer at 5.
    fset(8'h05, 8'h04);
    run(16'h1DC5);
    fget(8'h04, rv); check("rotr_ind", rv, 32'h00000081);
    // Subtract W from register giving zero.
    fset(8'h06, 8'h05); wr(OFS_ACC, 32'h00000005); wr(OFS_STATUS, 32'h00000000);
    run(16'h1F06);
    rd(OFS_ACC, rv); check("subf_w", rv, 32'h00000000);
    rd(OFS_STATUS, rv); check("subf_flags", rv, 32'h00000007);
    // Subtract with a borrow from the low nibble.
    wr(OFS_ACC, 32'h00000010);
    run(16'h0D01);
    rd(OFS_ACC, rv); check("subl_w", rv, 32'h0000000F);
    rd(OFS_STATUS, rv); check("subl_flags", rv, 32'h00000001);
    // Literal with its top bit set stays a one-cycle literal operation.
    wr(OFS_ACC, 32'h00000090); wr(OFS_STATUS, 32'h00000006);
    run(16'h0D81);
    rd(OFS_ACC, rv); check("subl_hi", rv, 32'h0000000F);
    rd(OFS_STATUS, rv); check("subl_hi_flags", rv, 32'h00000001);
    // Subtract into the register with a borrow out.
    fset(8'h06, 8'h02); wr(OFS_ACC, 32'h00000003);
    run(16'h1F46);
    fget(8'h06, rv); check("subf_f", rv, 32'h000000FF);
    rd(OFS_STATUS, rv); check("subf_borrow", rv, 32'h00000000);
    // Nibble exchange keeps flags.
    fset(8'h07, 8'h3C); wr(OFS_STATUS, 32'h00000005);
    run(16'h1A47);
    fget(8'h07, rv); check("swap_val", rv, 32'h000000C3);
    rd(OFS_STATUS, rv); check("swap_flags", rv, 32'h00000005);
    // Xor immediate to zero and to nonzero.
    wr(OFS_ACC, 32'h000000AA); wr(OFS_STATUS, 32'h00000000);
    run(16'h0BAA);
    rd(OFS_STATUS, rv); check("xor_z", rv, 32'h00000004);
    run(16'h0B0F);
    rd(OFS_ACC, rv); check("xor_w", rv, 32'h0000000F);
    rd(OFS_STATUS, rv); check("xor_nz", rv, 32'h00000000);
    // Skip on zero and on nonzero.
    fset(8'h08, 8'h00); snap = skip_cnt;
    run(16'h2008);
    check("skip_zero", skip_cnt - snap, 32'h00000001);
    fset(8'h08, 8'h01);
    run(16'h2008);
    check("skip_nz", skip_cnt - snap, 32'h00000001);
    // Indirect skip through a pointer in file byte 10.
    fset(8'h0A, 8'h08); fset(8'h08, 8'h00);
    run(16'h208A);
    check("skip_ind", skip_cnt - snap, 32'h00000002);
    rd(OFS_STATUS, rv); check("skip_flags", rv, 32'h00000000);
    // Table reads with the top page bits set, odd then even operand.
    wr(OFS_TPB, 32'h000000EE); fset(8'h09, 8'h55); wr(OFS_STATUS, 32'h00000003); snap = pmrd_cnt;
    run(16'h2F49);
    check("tbl_addr", {19'h0, pm_addr}, 32'h0000172A);
    rd(OFS_ACC, rv); check("tbl_hi", rv, 32'h000000B7);
    fset(8'h09, 8'h54);
    run(16'h2F49);
    rd(OFS_ACC, rv); check("tbl_lo", rv, 32'h0000002A);
    check("tbl_reads", pmrd_cnt - snap, 32'h00000002);
    rd(OFS_STATUS, rv); check("tbl_flags", rv, 32'h00000003);
    // Unknown opcode sets the sticky flag, write one clears it.
    run(16'hFF00);
    rd(OFS_STATUS, rv); check("illegal_set", {31'h0, rv[ST_ILLEGAL]}, 32'h00000001);
    wr(OFS_STATUS, 32'h00000010);
    rd(OFS_STATUS, rv); check("illegal_clr", {31'h0, rv[ST_ILLEGAL]}, 32'h00000000);
    // Sleep stops the oscillator until a wake request.
    wr(OFS_INSTR, {16'h0000, OPC_SLEEP});
    repeat (6) @(posedge pclk);
    check("sleep_osc", {31'h0, osc_run}, 32'h00000000);
    check("sleep_analog", {31'h0, analog_pwr_en}, 32'h00000001);
    rd(OFS_STATUS, rv); check("sleep_flag", {31'h0, rv[ST_SLEEP]}, 32'h00000001);
    irq_wake <= 1'b1;
    run(16'h0B00);
    irq_wake <= 1'b0;
    check("wake_osc", {31'h0, osc_run}, 32'h00000001);
    close_out();
  end

  // Cuts a hang short.
  initial begin
    #400000;
    num_errors++;
    close_out();
  end
endmodule
